// ### inc/bound_check_regs.vh
// Overview of operation
// RULE1: Compare indirect loads against exclusive 4K bound.
// RULE2: Loads at or above bound return zero.
// RULE3: Bound field zero disables the check.
// RULE4: Bound field all ones disables the check.
// RULE5: Issuer keeps non-zero bound above base.
// RULE6: Commands without indirect data skip the check.
// RULE7: Bound loads only when modify bit set.
`ifndef BOUND_CHECK_REGS_VH
`define BOUND_CHECK_REGS_VH

// ==========================================================
// State dword field layout
`define BOUND_MSB 31
`define BOUND_LSB 12
`define BOUND_W 20
`define RESERVED_MSB 11
`define RESERVED_LSB 1
`define MODIFY_EN_BIT 0

// ==========================================================
// Bound values
`define BOUND_RESET 20'h00000
`define BOUND_OFF_ZERO 20'h00000
`define BOUND_OFF_ONES 20'hfffff
`define RESERVED_ZERO 11'h000

// ==========================================================
// Address layout
`define ADDR_W 32
`define PAGE_MSB 31
`define PAGE_LSB 12

`endif

// ### logic/bound_compare.v
`timescale 1ns/100ps
`include "bound_check_regs.vh"

module bound_compare #(
    parameter W = `BOUND_W
) (
    // Programmed bound and request page
    input wire [W-1:0] bound_in,
    input wire [W-1:0] page_in,
    // Check enable for the current command
    input wire active_in,
    // Result
    output wire blocked_out
);

    wire disabled;

    // Either reserved bound value turns the check off
    assign disabled = (bound_in == `BOUND_OFF_ZERO) || // RULE3
                      (bound_in == `BOUND_OFF_ONES);   // RULE4

    // Bound is exclusive, so equality is already out of range
    assign blocked_out = active_in && !disabled && (page_in >= bound_in); // RULE1

endmodule // bound_compare

// ### logic/indirect_object_bound_check.v
`timescale 1ns/100ps
`include "bound_check_regs.vh"

module indirect_object_bound_check #(
    parameter DATA_W = 64,
    parameter COUNT_W = 16
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_in,
    // State command dword from the command streamer
    input wire state_valid_in,
    input wire [31:0] state_dword_in,
    // Media work command start
    input wire cmd_start_in,
    input wire cmd_has_indirect_in,
    // Indirect load requests from the fetch unit
    input wire req_valid_in,
    input wire [`ADDR_W-1:0] req_addr_in,
    output wire req_ready_out,
    // Load answers to the fetch unit
    output wire rsp_valid_out,
    output wire [DATA_W-1:0] rsp_data_out,
    input wire rsp_ready_in,
    // Memory read path
    output wire mem_req_valid_out,
    output wire [`ADDR_W-1:0] mem_req_addr_out,
    input wire mem_req_ready_in,
    input wire mem_rsp_valid_in,
    input wire [DATA_W-1:0] mem_rsp_data_in,
    // Status
    input wire stat_clear_in,
    output wire [`BOUND_W-1:0] bound_out,
    output wire check_active_out,
    output wire reserved_error_out,
    output wire [COUNT_W-1:0] blocked_count_out
);

    // ==========================================================
    // State encoding
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ISSUE = 2'h1;
    localparam [1:0] ST_WAIT = 2'h2;
    localparam [1:0] ST_RESP = 2'h3;

    localparam [COUNT_W-1:0] COUNT_ONE = {{(COUNT_W-1){1'b0}}, 1'b1};
    localparam [COUNT_W-1:0] COUNT_MAX = {COUNT_W{1'b1}};
    localparam [DATA_W-1:0] ZERO_DATA = {DATA_W{1'b0}};

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [`BOUND_W-1:0] bound_reg;
    reg active_reg;
    reg reserved_err_reg;
    reg [COUNT_W-1:0] count_reg;
    reg [COUNT_W-1:0] count_next;
    reg [`ADDR_W-1:0] addr_reg;
    reg [DATA_W-1:0] data_reg;
    reg rsp_valid_reg;

    wire blocked;
    wire take_req;
    wire load_bound;
    wire reserved_set;

    // ==========================================================
    // Bound storage
    // Only the modify bit lets a dword replace the bound
    assign load_bound = state_valid_in && state_dword_in[`MODIFY_EN_BIT]; // RULE7

    // Reserved bits must be zero; flag any violation
    assign reserved_set = state_valid_in &&
        (state_dword_in[`RESERVED_MSB:`RESERVED_LSB] != `RESERVED_ZERO);

    // Keep the old bound when the modify bit is clear
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bound_reg <= `BOUND_RESET;
        end else if (load_bound) begin
            bound_reg <= state_dword_in[`BOUND_MSB:`BOUND_LSB]; // RULE7
        end
    end

    // Per-command check enable
    // A command without indirect data never consults the bound
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            active_reg <= 1'b0;
        end else if (cmd_start_in) begin
            active_reg <= cmd_has_indirect_in; // RULE6
        end
    end

    // Sticky reserved-bit flag; a new violation beats the clear
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reserved_err_reg <= 1'b0;
        end else if (reserved_set) begin
            reserved_err_reg <= 1'b1;
        end else if (stat_clear_in) begin
            reserved_err_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Range check
    // Non-zero bound above base is trusted from the issuer
    bound_compare #(
        .W(`BOUND_W)
    ) u_compare (
        .bound_in(bound_reg),
        .page_in(req_addr_in[`PAGE_MSB:`PAGE_LSB]),
        .active_in(active_reg),
        .blocked_out(blocked)
    );

    // ==========================================================
    // Request sequencing
    // One load in flight keeps zeroed answers in order
    assign req_ready_out = (state_reg == ST_IDLE);
    assign take_req = req_valid_in && req_ready_out;

    // Next state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take_req && blocked) begin
                    state_next = ST_RESP;
                end else if (take_req) begin
                    state_next = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                if (mem_req_ready_in) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (mem_rsp_valid_in) begin
                    state_next = ST_RESP;
                end
            end
            ST_RESP: begin
                if (rsp_ready_in) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // State register
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Request address capture
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_reg <= {`ADDR_W{1'b0}};
        end else if (take_req) begin
            addr_reg <= req_addr_in;
        end
    end

    // Answer data and valid
    // Blocked loads never reach memory, saving a wasted fetch
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_reg <= ZERO_DATA;
            rsp_valid_reg <= 1'b0;
        end else begin
            if (state_reg == ST_IDLE && take_req && blocked) begin
                data_reg <= ZERO_DATA; // RULE2
                rsp_valid_reg <= 1'b1;
            end else if (state_reg == ST_WAIT && mem_rsp_valid_in) begin
                data_reg <= mem_rsp_data_in;
                rsp_valid_reg <= 1'b1;
            end else if (state_reg == ST_RESP && rsp_ready_in) begin
                rsp_valid_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Blocked load counter
    // Saturates rather than wraps; a blocked load in the clear cycle restarts the count at one
    always @* begin
        count_next = count_reg;
        if (take_req && blocked) begin
            if (stat_clear_in) begin
                count_next = COUNT_ONE;
            end else if (count_reg != COUNT_MAX) begin
                count_next = count_reg + COUNT_ONE;
            end
        end else if (stat_clear_in) begin
            count_next = {COUNT_W{1'b0}};
        end
    end

    // Counter register
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_reg <= {COUNT_W{1'b0}};
        end else begin
            count_reg <= count_next;
        end
    end

    // ==========================================================
    // Outputs
    assign mem_req_valid_out = (state_reg == ST_ISSUE);
    assign mem_req_addr_out = addr_reg;
    assign rsp_valid_out = rsp_valid_reg;
    assign rsp_data_out = data_reg;
    assign bound_out = bound_reg;
    assign check_active_out = active_reg;
    assign reserved_error_out = reserved_err_reg;
    assign blocked_count_out = count_reg;

endmodule // indirect_object_bound_check

// ### verification/bound_check_sva.sv
`timescale 1ns/100ps
// ====================
// Port checker
module bound_chk #(
    parameter DATA_W = 64
) (
    // Watched ports
    input logic clk_in,
    input logic rst_in,
    input logic state_valid_in,
    input logic [31:0] state_dword_in,
    input logic cmd_start_in,
    input logic cmd_has_indirect_in,
    input logic req_valid_in,
    input logic [31:0] req_addr_in,
    input logic req_ready_out,
    input logic rsp_valid_out,
    input logic [DATA_W-1:0] rsp_data_out,
    input logic mem_req_valid_out,
    input logic [19:0] bound_out,
    input logic check_active_out
);
    // Shared qualifiers
    wire ld = state_valid_in && state_dword_in[0];
    wire acc = req_valid_in && req_ready_out;
    wire on = check_active_out && bound_out != 20'h00000 && bound_out != 20'hfffff;
    wire hit = acc && on && req_addr_in[31:12] >= bound_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_load; ld |=> bound_out == $past(state_dword_in[31:12]); endproperty
    a_load: assert property (p_load) else $error("bound not loaded");
    property p_keep; !ld |=> $stable(bound_out); endproperty
    a_keep: assert property (p_keep) else $error("bound changed");
    property p_zero; hit |=> rsp_valid_out && rsp_data_out == '0 && !mem_req_valid_out; endproperty
    a_zero: assert property (p_zero) else $error("blocked load");
    property p_low; acc && on && req_addr_in[31:12] < bound_out |=> mem_req_valid_out; endproperty
    a_low: assert property (p_low) else $error("load below bound");
    property p_off0; acc && bound_out == 20'h00000 |=> mem_req_valid_out; endproperty
    a_off0: assert property (p_off0) else $error("zero bound");
    property p_off1; acc && bound_out == 20'hfffff |=> mem_req_valid_out; endproperty
    a_off1: assert property (p_off1) else $error("ones bound");
    property p_noind; acc && !check_active_out |=> mem_req_valid_out; endproperty
    a_noind: assert property (p_noind) else $error("unchecked load");
    property p_act; cmd_start_in |=> check_active_out == $past(cmd_has_indirect_in); endproperty
    a_act: assert property (p_act) else $error("check flag");
endmodule // bound_chk

bind indirect_object_bound_check bound_chk #(.DATA_W(DATA_W)) u_chk (
    .clk_in, .rst_in, .state_valid_in, .state_dword_in, .cmd_start_in,
    .cmd_has_indirect_in, .req_valid_in, .req_addr_in, .req_ready_out,
    .rsp_valid_out, .rsp_data_out, .mem_req_valid_out, .bound_out, .check_active_out);

// ### verification/mem_model.sv
`timescale 1ns/100ps
// ====================
// Memory read path
module mem_model (
    // Requests
    input wire clk_in,
    input wire req_valid_in,
    input wire [31:0] req_addr_in,
    input wire slow_in,
    // Answers
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [63:0] rsp_data_out
);
    logic [31:0] a_reg;
    initial req_ready_out = 1'h0;
    initial rsp_valid_out = 1'h0;
    initial rsp_data_out = 64'h0;
    // Data flips outside the pulse so stale reads fail
    always begin
        @(posedge clk_in);
        #1 rsp_valid_out = 1'h0;
        rsp_data_out = ~rsp_data_out;
        if (req_valid_in) begin
            repeat (slow_in ? 2 : 0) @(posedge clk_in);
            #1 req_ready_out = 1'h1;
            a_reg = req_addr_in;
            @(posedge clk_in);
            #1 req_ready_out = 1'h0;
            repeat (slow_in ? 2 : 0) @(posedge clk_in);
            #1 rsp_valid_out = 1'h1;
            rsp_data_out = {~a_reg, a_reg};
        end
    end
endmodule // mem_model

// ### verification/tb.sv
`timescale 1ns/100ps
// ====================
// Testbench
module tb;
    logic clk_in = 1'h0, rst_in = 1'h1, state_valid_in = 1'h0, cmd_start_in = 1'h0;
    logic cmd_has_indirect_in = 1'h0, req_valid_in = 1'h0, rsp_ready_in = 1'h0, slow = 1'h0;
    logic [31:0] state_dword_in = 32'h0, req_addr_in = 32'h0;
    logic stat_clear = 1'h0;
    wire check_active_out, reserved_error_out;
    wire req_ready_out, rsp_valid_out, mem_req_valid_out, mem_req_ready_in, mem_rsp_valid_in;
    wire [63:0] rsp_data_out, mem_rsp_data_in;
    wire [31:0] mem_req_addr_out;
    wire [19:0] bound_out;
    wire [15:0] blocked_count_out;
    int mismatches = 0;
    int n_compared = 0;
    always #2.5 clk_in = ~clk_in;
    indirect_object_bound_check dut (.clk_in, .rst_in, .state_valid_in, .state_dword_in,
        .cmd_start_in, .cmd_has_indirect_in, .req_valid_in, .req_addr_in, .req_ready_out,
        .rsp_valid_out, .rsp_data_out, .rsp_ready_in, .mem_req_valid_out, .mem_req_addr_out,
        .mem_req_ready_in, .mem_rsp_valid_in, .mem_rsp_data_in, .stat_clear_in(stat_clear),
        .bound_out, .check_active_out, .reserved_error_out, .blocked_count_out);
    mem_model mem (.clk_in, .req_valid_in(mem_req_valid_out), .req_addr_in(mem_req_addr_out),
        .slow_in(slow), .req_ready_out(mem_req_ready_in), .rsp_valid_out(mem_rsp_valid_in),
        .rsp_data_out(mem_rsp_data_in));
    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task step;
        @(posedge clk_in);
        #1;
    endtask
    task st(input logic [31:0] d);
        state_dword_in = d;
        state_valid_in = 1'h1;
        step;
        state_valid_in = 1'h0;
        step;
    endtask
    task cmd(input logic ind);
        cmd_has_indirect_in = ind;
        cmd_start_in = 1'h1;
        step;
        cmd_start_in = 1'h0;
        step;
        chk(check_active_out, ind);
    endtask
    // One load; answer held one stall cycle to see it stand
    task ld(input logic [31:0] a, input logic blk);
        int n;
        n = 0;
        req_addr_in = a;
        req_valid_in = 1'h1;
        while (req_ready_out !== 1'h1 && n < 9) begin
            step;
            n++;
        end
        step;
        req_valid_in = 1'h0;
        while (rsp_valid_out !== 1'h1 && n < 30) begin
            step;
            n++;
        end
        step;
        chk(rsp_valid_out, 1'h1);
        chk(rsp_data_out, blk ? 64'h0 : {~a, a});
        rsp_ready_in = 1'h1;
        step;
        rsp_ready_in = 1'h0;
    endtask
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Tests
    initial begin
        repeat (12) @(posedge clk_in);
        #1 rst_in = 1'h0;
        step;
        chk(bound_out, 20'h0);
        ld(32'h00345678, 1'h0);
        cmd(1'h1);
        ld(32'hfff00000, 1'h0);
        st(32'h00010001);
        chk(bound_out, 20'h00010);
        chk(reserved_error_out, 1'h0);
        ld(32'h0000fffc, 1'h0);
        ld(32'h00010000, 1'h1);
        slow = 1'h1;
        ld(32'h0000f000, 1'h0);
        st(32'h00020ffe);
        chk(bound_out, 20'h00010);
        chk(reserved_error_out, 1'h1);
        ld(32'hffff0000, 1'h1);
        cmd(1'h0);
        ld(32'h00010000, 1'h0);
        cmd(1'h1);
        st(32'hfffff001);
        ld(32'hfffff000, 1'h0);
        chk(blocked_count_out, 16'h0002);
        // Status clear drops both the flag and the count
        stat_clear = 1'h1;
        step;
        stat_clear = 1'h0;
        chk(reserved_error_out, 1'h0);
        chk(blocked_count_out, 16'h0000);
        give_verdict;
    end
    // Watchdog
    initial begin
        #20000;
        mismatches++;
        give_verdict;
    end
endmodule // tb
